// ==== design/sfw_pkg.sv ====
// Contract
// - Status write needs write enable first.
// - Host sends status opcode then one byte.
// - Status write clears the enable latch.
// - Bit 0 follows internal busy state only.
// - Bits 6 and 5 always read zero.
// - Status write updates disable and protect bits.
// - Pin low plus disable bit blocks status writes.
// - Hard protection entered either order, left pin-high.
// - Hard protection freezes status bits only.
// - Parallel mode entered by 55h, left 45h.
// - Parallel mode moves one byte per clock.
// - Program clears bits only, needs enable.
// - Host sends opcode, address MSB first, data.
// - Keep last 256 bytes, wrap to page start.
// - Program starts on byte-aligned select rise.
// - Busy bit set during work, latch cleared.
// - Program to protected page is refused.
// - Sector erase 20h/D8h sets sector, needs enable.
// - Erase takes opcode plus three address bytes.
// - Erase starts on byte-aligned select rise.
// - Erase of protected sector is refused.
// - Latch set, cleared, and auto-cleared when a write is accepted.
// - Latch zero rejects write-type commands.
package sfw_pkg;

    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SECTOR_ERASE_A = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE_B = 8'hd8;
    localparam logic [7:0] OP_PAR_ENTER = 8'h55;
    localparam logic [7:0] OP_PAR_EXIT = 8'h45;

    // Status byte layout.
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 4;
    localparam int ST_STATUS_WRITE_DISABLE = 7;

    localparam int PAGE_BYTES = 256;
    localparam int PROG_CYCLES = 512;
    localparam int ERASE_CYCLES = 8192;

    // Link clock made by the host divider.
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCK_PERIOD_NS = 320;
    localparam int PAR_MAX_MHZ = 10;
    localparam int SCK_HALF = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // Host controller registers.
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_TX = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam int CTRL_PROTECT = 0;
    localparam int CTRL_PAR = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int TX_LAST = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_CS = 1;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_PROG = 2'b01,
        DEV_ERASE = 2'b10,
        DEV_WAIT = 2'b11
    } sfw_dev_e;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_LOW = 2'b01,
        HST_HIGH = 2'b10,
        HST_END = 2'b11
    } sfw_host_e;

endpackage

// ==== design/sfw_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sfw_link_if;
    logic cs_n;
    logic sck;
    logic sdi;
    logic [7:0] par_data;
    logic protect_pin;

    modport host (
        output cs_n,
        output sck,
        output sdi,
        output par_data,
        output protect_pin
    );

    modport flash (
        input cs_n,
        input sck,
        input sdi,
        input par_data,
        input protect_pin
    );
endinterface
`default_nettype wire

// ==== design/sfw_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= RST;
            q <= RST;
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ==== design/sfw_flash.sv ====
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfw_flash #(
    parameter int MEM_AW = 16,
    parameter int SECT_AW = 12,
    parameter int CNT_W = 16,
    parameter int PROG_CYC = sfw_pkg::PROG_CYCLES,
    parameter int ERASE_CYC = sfw_pkg::ERASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    sfw_link_if.flash link,
    input wire logic [MEM_AW-1:0] peek_addr,
    output logic [7:0] peek_data,
    output logic [7:0] device_state_reg,
    output logic par_mode
);
    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [11:0] pins_s;
    logic s_cs_n;
    logic s_sck;
    logic s_sdi;
    logic s_prot;
    logic [7:0] s_par;
    logic sck_q_ff;
    logic cs_q_ff;
    logic sck_rise;
    logic cs_rise;

    sfw_sync #(.W(12), .RST(12'h900)) sfw_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.cs_n, link.sck, link.sdi, link.protect_pin,
            link.par_data}),
        .q(pins_s)
    );

    assign {s_cs_n, s_sck, s_sdi, s_prot, s_par} = pins_s;
    assign sck_rise = s_sck & ~sck_q_ff;
    assign cs_rise = s_cs_n & ~cs_q_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_q_ff <= 1'b0;
            cs_q_ff <= 1'b1;
        end
        else
        begin
            sck_q_ff <= s_sck;
            cs_q_ff <= s_cs_n;
        end
    end

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    logic [2:0] bit_ff;
    logic [6:0] shreg_ff;
    logic byte_done;
    logic [7:0] in_byte;
    logic par_mode_ff;

    assign byte_done = sck_rise & ~s_cs_n & (par_mode_ff | bit_ff == 3'h7);
    assign in_byte = par_mode_ff ? s_par : {shreg_ff, s_sdi};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_ff <= 3'h0;
            shreg_ff <= 7'h00;
        end
        else if (s_cs_n)
        begin
            bit_ff <= 3'h0;
        end
        else if (sck_rise && !par_mode_ff)
        begin
            bit_ff <= bit_ff + 3'h1;
            shreg_ff <= {shreg_ff[5:0], s_sdi};
        end
    end

    // ------------------------------------------------------------
    // Frame capture: opcode, address, data count
    // ------------------------------------------------------------
    logic [2:0] nbyte_ff;
    logic [7:0] opcode_ff;
    logic [23:0] addr_ff;
    logic [7:0] sdata_ff;
    logic [8:0] wcnt_ff;
    logic ovf_ff;
    sfw_pkg::sfw_dev_e state_ff;
    logic [7:0] pbuf [sfw_pkg::PAGE_BYTES];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nbyte_ff <= 3'h0;
            opcode_ff <= 8'h00;
            addr_ff <= 24'h000000;
            sdata_ff <= 8'h00;
            wcnt_ff <= 9'h000;
            ovf_ff <= 1'b0;
        end
        else if (s_cs_n)
        begin
            nbyte_ff <= 3'h0;
            wcnt_ff <= 9'h000;
            ovf_ff <= 1'b0;
        end
        else if (byte_done)
        begin
            if (nbyte_ff != 3'h5)
                nbyte_ff <= nbyte_ff + 3'h1;
            if (nbyte_ff == 3'h0)
                opcode_ff <= in_byte;
            else if (nbyte_ff <= 3'h3)
                addr_ff <= {addr_ff[15:0], in_byte};
            if (nbyte_ff == 3'h1)
                sdata_ff <= in_byte;
            if (nbyte_ff >= 3'h4)
            begin
                wcnt_ff <= {1'b0, wcnt_ff[7:0]} + 9'h001;
                if (wcnt_ff[8])
                    ovf_ff <= 1'b1;
            end
        end
    end

    // Ring buffer keeps only the newest page worth of bytes.
    always_ff @(posedge pclk)
    begin
        if (byte_done && nbyte_ff >= 3'h4 && state_ff == sfw_pkg::DEV_IDLE)
            pbuf[wcnt_ff[7:0]] <= in_byte;
    end

    // ------------------------------------------------------------
    // Command execution and status
    // ------------------------------------------------------------
    logic wel_ff;
    logic status_write_disable_ff;
    logic [2:0] bp_ff;
    logic hpm_ff;
    logic [SECT_AW-1:0] idx_ff;
    logic [CNT_W-1:0] wait_ff;
    logic [MEM_AW-9:0] page_ff;
    logic [MEM_AW-SECT_AW-1:0] sect_ff;
    logic [7:0] col0_ff;
    logic [7:0] first_ff;
    logic [8:0] n_ff;
    logic aligned;
    logic target_prot;

    function automatic logic is_prot(input logic [2:0] bp,
                                     input logic [MEM_AW-SECT_AW-1:0] sec);
        int nsec;
        int cnt;
        nsec = 1 << (MEM_AW - SECT_AW);
        if (bp == 3'h0)
            return 1'b0;
        cnt = 1 << (int'(bp) - 1);
        return int'(sec) >= nsec - cnt;
    endfunction

    assign aligned = cs_rise & bit_ff == 3'h0 & state_ff == sfw_pkg::DEV_IDLE;
    assign target_prot = is_prot(bp_ff, addr_ff[MEM_AW-1:SECT_AW]);

    // Entered once both pin low and disable bit are present.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hpm_ff <= 1'b0;
        else if (s_prot)
            hpm_ff <= 1'b0;
        else if (status_write_disable_ff)
            hpm_ff <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= sfw_pkg::DEV_IDLE;
            wel_ff <= 1'b0;
            status_write_disable_ff <= 1'b0;
            bp_ff <= 3'h0;
            par_mode_ff <= 1'b0;
            idx_ff <= '0;
            wait_ff <= '0;
            page_ff <= '0;
            sect_ff <= '0;
            col0_ff <= 8'h00;
            first_ff <= 8'h00;
            n_ff <= 9'h000;
        end
        else
        begin
            if (wait_ff != '0)
                wait_ff <= wait_ff - 1'b1;
            unique case (state_ff)
                sfw_pkg::DEV_IDLE:
                begin
                    if (aligned)
                    begin
                        case (opcode_ff)
                            sfw_pkg::OP_WRITE_ENABLE:
                                if (nbyte_ff == 3'h1)
                                    wel_ff <= 1'b1;
                            sfw_pkg::OP_WRITE_DISABLE:
                                if (nbyte_ff == 3'h1)
                                    wel_ff <= 1'b0;
                            sfw_pkg::OP_PAR_ENTER:
                                if (nbyte_ff == 3'h1)
                                    par_mode_ff <= 1'b1;
                            sfw_pkg::OP_PAR_EXIT:
                                if (nbyte_ff == 3'h1)
                                    par_mode_ff <= 1'b0;
                            sfw_pkg::OP_STATUS_WRITE:
                                // Latch and busy bit are not taken from data.
                                if (nbyte_ff == 3'h2 && wel_ff && !hpm_ff)
                                begin
                                    status_write_disable_ff <= sdata_ff[sfw_pkg::ST_STATUS_WRITE_DISABLE];
                                    bp_ff <= sdata_ff[sfw_pkg::ST_BP_HI:
                                                      sfw_pkg::ST_BP_LO];
                                    wel_ff <= 1'b0;
                                end
                            sfw_pkg::OP_PAGE_PROGRAM:
                                if (nbyte_ff == 3'h5 && wel_ff && !target_prot)
                                begin
                                    state_ff <= sfw_pkg::DEV_PROG;
                                    wel_ff <= 1'b0;
                                    idx_ff <= '0;
                                    wait_ff <= CNT_W'(PROG_CYC - 1);
                                    page_ff <= addr_ff[MEM_AW-1:8];
                                    col0_ff <= ovf_ff ? 8'h00 : addr_ff[7:0];
                                    first_ff <= ovf_ff ? wcnt_ff[7:0] : 8'h00;
                                    n_ff <= ovf_ff ? 9'h100 : wcnt_ff;
                                end
                            sfw_pkg::OP_SECTOR_ERASE_A,
                            sfw_pkg::OP_SECTOR_ERASE_B:
                                if (nbyte_ff == 3'h4 && wel_ff && !target_prot)
                                begin
                                    state_ff <= sfw_pkg::DEV_ERASE;
                                    wel_ff <= 1'b0;
                                    idx_ff <= '0;
                                    wait_ff <= CNT_W'(ERASE_CYC - 1);
                                    sect_ff <= addr_ff[MEM_AW-1:SECT_AW];
                                end
                            default:
                            begin
                            end
                        endcase
                    end
                end
                sfw_pkg::DEV_PROG:
                begin
                    idx_ff <= idx_ff + 1'b1;
                    if (idx_ff[7:0] == 8'hff)
                        state_ff <= sfw_pkg::DEV_WAIT;
                end
                sfw_pkg::DEV_ERASE:
                begin
                    idx_ff <= idx_ff + 1'b1;
                    if (&idx_ff)
                        state_ff <= sfw_pkg::DEV_WAIT;
                end
                sfw_pkg::DEV_WAIT:
                    if (wait_ff == '0)
                        state_ff <= sfw_pkg::DEV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------
    logic [7:0] mem [2**MEM_AW];
    logic [7:0] pcol;
    logic [7:0] pidx;

    assign pcol = col0_ff + idx_ff[7:0];
    assign pidx = first_ff + idx_ff[7:0];

    always_ff @(posedge pclk)
    begin
        if (state_ff == sfw_pkg::DEV_PROG && {1'b0, idx_ff[7:0]} < n_ff)
            mem[{page_ff, pcol}] <= mem[{page_ff, pcol}] & pbuf[pidx];
        else if (state_ff == sfw_pkg::DEV_ERASE)
            mem[{sect_ff, idx_ff}] <= 8'hff;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [7:0] nxt_status;

    always_comb
    begin
        nxt_status = 8'h00;
        nxt_status[sfw_pkg::ST_WIP] = state_ff != sfw_pkg::DEV_IDLE;
        nxt_status[sfw_pkg::ST_WEL] = wel_ff;
        nxt_status[sfw_pkg::ST_BP_HI:sfw_pkg::ST_BP_LO] = bp_ff;
        nxt_status[sfw_pkg::ST_STATUS_WRITE_DISABLE] = status_write_disable_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            device_state_reg <= 8'h00;
            par_mode <= 1'b0;
            peek_data <= 8'h00;
        end
        else
        begin
            device_state_reg <= nxt_status;
            par_mode <= par_mode_ff;
            peek_data <= mem[peek_addr];
        end
    end
endmodule
`default_nettype wire

// ==== design/sfw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfw_host #(
    parameter int HALF = sfw_pkg::SCK_HALF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sfw_link_if.host link
);
    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    sfw_pkg::sfw_host_e st_ff;
    logic [1:0] ctrl_ff;
    logic cs_n_ff;
    logic access;
    logic tx_wr;
    logic done;
    logic mapped;

    assign access = psel & penable;
    assign tx_wr = pwrite & paddr == sfw_pkg::REG_TX;
    assign done = access & pready;
    assign mapped = paddr == sfw_pkg::REG_CTRL | paddr == sfw_pkg::REG_TX
                  | paddr == sfw_pkg::REG_STATUS;

    // A byte write waits for the engine, stalling the bus master.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (pready)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (access && (!tx_wr || st_ff == sfw_pkg::HST_IDLE))
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= 32'h00000000;
            if (!pwrite && paddr == sfw_pkg::REG_CTRL)
                prdata[1:0] <= ctrl_ff;
            if (!pwrite && paddr == sfw_pkg::REG_STATUS)
            begin
                prdata[sfw_pkg::STAT_BUSY] <= st_ff != sfw_pkg::HST_IDLE;
                prdata[sfw_pkg::STAT_CS] <= !cs_n_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= sfw_pkg::CTRL_RST;
        else if (done && pwrite && paddr == sfw_pkg::REG_CTRL)
            ctrl_ff <= pwdata[1:0];
    end

    // ------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------
    logic [7:0] txb_ff;
    logic last_ff;
    logic [2:0] bits_ff;
    logic [7:0] div_ff;
    logic sck_ff;
    logic sdi_ff;
    logic [7:0] par_ff;
    logic prot_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= sfw_pkg::HST_IDLE;
            txb_ff <= 8'h00;
            last_ff <= 1'b0;
            bits_ff <= 3'h0;
            div_ff <= 8'h00;
            cs_n_ff <= 1'b1;
            sck_ff <= 1'b0;
            sdi_ff <= 1'b0;
            par_ff <= 8'h00;
        end
        else
        begin
            if (div_ff != 8'h00)
                div_ff <= div_ff - 8'h01;
            unique case (st_ff)
                sfw_pkg::HST_IDLE:
                    if (done && tx_wr)
                    begin
                        cs_n_ff <= 1'b0;
                        txb_ff <= pwdata[7:0];
                        last_ff <= pwdata[sfw_pkg::TX_LAST];
                        sdi_ff <= pwdata[7];
                        par_ff <= pwdata[7:0];
                        // One byte per clock when parallel.
                        bits_ff <= ctrl_ff[sfw_pkg::CTRL_PAR] ? 3'h0 : 3'h7;
                        div_ff <= 8'(HALF - 1);
                        st_ff <= sfw_pkg::HST_LOW;
                    end
                sfw_pkg::HST_LOW:
                    if (div_ff == 8'h00)
                    begin
                        sck_ff <= 1'b1;
                        div_ff <= 8'(HALF - 1);
                        st_ff <= sfw_pkg::HST_HIGH;
                    end
                sfw_pkg::HST_HIGH:
                    if (div_ff == 8'h00)
                    begin
                        sck_ff <= 1'b0;
                        div_ff <= 8'(HALF - 1);
                        if (bits_ff != 3'h0)
                        begin
                            bits_ff <= bits_ff - 3'h1;
                            txb_ff <= {txb_ff[6:0], 1'b0};
                            sdi_ff <= txb_ff[6];
                            st_ff <= sfw_pkg::HST_LOW;
                        end
                        else if (last_ff)
                            st_ff <= sfw_pkg::HST_END;
                        else
                            st_ff <= sfw_pkg::HST_IDLE;
                    end
                sfw_pkg::HST_END:
                    if (div_ff == 8'h00)
                    begin
                        cs_n_ff <= 1'b1;
                        st_ff <= sfw_pkg::HST_IDLE;
                    end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prot_ff <= 1'b1;
        else
            prot_ff <= ctrl_ff[sfw_pkg::CTRL_PROTECT];
    end

    assign link.cs_n = cs_n_ff;
    assign link.sck = sck_ff;
    assign link.sdi = sdi_ff;
    assign link.par_data = par_ff;
    assign link.protect_pin = prot_ff;
endmodule
`default_nettype wire

// ==== test/sfw_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfw_asserts #(
    parameter int BUSY = 300
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic [7:0] par_data,
    input wire logic protect_pin,
    input wire logic [7:0] device_state_reg
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // Busy length counter.
    // ------------------------------------------------------------------
    logic [15:0] busy_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_ff <= 16'h0;
        else
            busy_ff <= device_state_reg[0] ? busy_ff + 16'h1 : 16'h0;
    end
    sequence s_sck_high;
        sck [*4] ##1 !sck;
    endsequence
    AST_ZERO_65: assert property (device_state_reg[6:5] == 2'h0)
        else $error("status bits 6 and 5 not zero");
    AST_SCK_IDLE: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("link clock runs outside a frame");
    AST_SCK_PHASE: assert property ($rose(sck) |-> s_sck_high)
        else $error("link clock high phase wrong");
    AST_DATA_HOLD: assert property (sck && $past(sck) |->
        $stable(sdi) && $stable(par_data)) else $error("data moved in sck high");
    AST_CS_RISE: assert property ($rose(cs_n) |-> !sck && !$past(sck, 4))
        else $error("select rose off a byte boundary");
    AST_WIP_WEL: assert property ($rose(device_state_reg[0]) |->
        ##[0:4] !device_state_reg[1]) else $error("latch not cleared in busy");
    AST_WIP_LEN: assert property ($fell(device_state_reg[0]) |->
        busy_ff >= BUSY - 1 && busy_ff <= BUSY + 1) else $error("busy length");
    AST_WEL_CS: assert property ($changed(device_state_reg[1]) |->
        cs_n && $past(cs_n, 2)) else $error("latch moved inside a frame");
endmodule
`default_nettype wire

// ==== test/serial_flash_write_erase_protect_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_erase_protect_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] peek_addr = 16'h0;
    logic [7:0] peek_data;
    logic [7:0] st;
    logic par_mode;
    logic [31:0] rd;
    logic err;
    logic [7:0] big[$];
    int errors = 0;
    int comparisons = 0;
    sfw_link_if link ();
    sfw_host sfw_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    sfw_flash #(.SECT_AW(8), .PROG_CYC(300), .ERASE_CYC(300)) sfw_flash_inst (
        .pclk(pclk), .presetn(presetn), .link(link.flash),
        .peek_addr(peek_addr), .peek_data(peek_data),
        .device_state_reg(st), .par_mode(par_mode));
    sfw_asserts #(.BUSY(300)) sfw_asserts_inst (.pclk(pclk),
        .presetn(presetn), .cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi),
        .par_data(link.par_data), .protect_pin(link.protect_pin),
        .device_state_reg(st));
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ------------------------------------------------------------------
    // Bus cycles and link frames.
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fr(input logic [7:0] q[$]);
        foreach (q[i])
        begin
            apb(1'b1, sfw_pkg::REG_TX, {23'h0, i == q.size() - 1, q[i]});
            do
                apb(1'b0, sfw_pkg::REG_STATUS, 32'h0);
            while (rd[sfw_pkg::STAT_BUSY] !== 1'b0);
        end
        repeat (8) @(posedge pclk);
    endtask
    task automatic idle();
        for (int n = 0; n < 1000 && st[0] !== 1'b0; n++)
            @(posedge pclk);
    endtask
    task automatic pk(input logic [15:0] a, input logic [7:0] exp);
        peek_addr <= a;
        repeat (2) @(posedge pclk);
        chk("memory", peek_data, exp);
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("state", st, 8'h00);
        apb(1'b0, sfw_pkg::REG_CTRL, 32'h0);
        chk("ctrl", rd[7:0], 8'h01);
        apb(1'b0, 12'h00c, 32'h0);
        chk("slverr", {7'h0, err}, 8'h01);
        apb(1'b1, sfw_pkg::REG_TX, 32'h06);
        repeat (80) @(posedge pclk);
        apb(1'b0, sfw_pkg::REG_STATUS, 32'h0);
        chk("status", rd[7:0], 8'h02);
        fr('{8'h00});
        fr('{8'h01, 8'h9c});
        chk("state", st, 8'h00);
        fr('{8'h06});
        chk("state", st, 8'h02);
        fr('{8'h04});
        chk("state", st, 8'h00);
        fr('{8'h06});
        fr('{8'h01, 8'hff});
        chk("state", st, 8'h9c);
        apb(1'b1, sfw_pkg::REG_CTRL, 32'h0);
        fr('{8'h06});
        fr('{8'h01, 8'h00});
        chk("state", st, 8'h9e);
        apb(1'b1, sfw_pkg::REG_CTRL, 32'h1);
        fr('{8'h01, 8'h84});
        chk("state", st, 8'h84);
        apb(1'b1, sfw_pkg::REG_CTRL, 32'h0);
        fr('{8'h06});
        fr('{8'h01, 8'h00});
        chk("state", st, 8'h86);
        fr('{8'h20, 8'h00, 8'h00, 8'h12});
        chk("state", st, 8'h85);
        idle();
        chk("state", st, 8'h84);
        pk(16'h0000, 8'hff);
        fr('{8'h06});
        fr('{8'h02, 8'h00, 8'h00, 8'h10, 8'ha5, 8'h3c});
        idle();
        pk(16'h0010, 8'ha5);
        pk(16'h0011, 8'h3c);
        fr('{8'h06});
        fr('{8'h02, 8'h00, 8'h00, 8'h10, 8'h0f});
        idle();
        pk(16'h0010, 8'h05);
        fr('{8'h02, 8'h00, 8'h00, 8'h11, 8'h00});
        idle();
        pk(16'h0011, 8'h3c);
        fr('{8'h06});
        fr('{8'hd8, 8'h00, 8'hff, 8'h40});
        chk("state", st, 8'h86);
        fr('{8'h02, 8'h00, 8'hff, 8'h00, 8'h00});
        chk("state", st, 8'h86);
        fr('{8'h20, 8'h00, 8'h01});
        chk("state", st, 8'h86);
        fr('{8'hd8, 8'h00, 8'h01, 8'h77});
        idle();
        fr('{8'h06});
        big = '{8'h02, 8'h00, 8'h01, 8'h40};
        for (int i = 0; i < 258; i++)
            big.push_back(8'(i));
        fr(big);
        idle();
        pk(16'h0100, 8'h02);
        pk(16'h01ff, 8'h01);
        fr('{8'h55});
        apb(1'b1, sfw_pkg::REG_CTRL, 32'h2);
        chk("par", {7'h0, par_mode}, 8'h01);
        fr('{8'h06});
        chk("state", st, 8'h86);
        fr('{8'h45});
        apb(1'b1, sfw_pkg::REG_CTRL, 32'h1);
        chk("par", {7'h0, par_mode}, 8'h00);
        summarize();
    end
    initial
    begin
        #2000000;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
